// >>> hw/speed_reference_selector.sv
// Speed reference selector with Modbus RTU frequency register
`include "speed_ref_params.svh"
`timescale 1ns/1ps
`default_nettype none
module speed_reference_selector
    import speed_ref_pkg::*;
#(
    parameter int         BIT_CYC   = (`CLK_HZ + `BAUD_DEF / 2) / `BAUD_DEF,
    parameter int         GAP_CYC   = BIT_CYC * `GAP_BIT_TIMES,
    parameter int         GATE_CYC  = `CLK_HZ / 1000 * `GATE_MS,
    parameter int         RAMP_CYC  = `CLK_HZ / 1000 * `RAMP_MS,
    parameter logic [15:0] RAMP_STEP = 16'h0001,
    parameter logic [15:0] UD_STEP   = 16'h0001,
    parameter logic [7:0]  NODE_ADDR = `NODE_ADDR_DEF
) (
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    input  wire cfg_t        i_cfg,
    input  wire keys_t       i_keys,
    input  wire logic        i_term_up,
    input  wire logic        i_term_down,
    input  wire logic [11:0] i_analog_input_master,
    input  wire logic [11:0] i_analog_input_auxiliary,
    input  wire logic [15:0] i_pid_out,
    input  wire logic [15:0] i_max_freq,
    input  wire logic        i_pulse_input_terminal,
    input  wire logic        i_rs485_rx,
    output logic [15:0]      o_freq_ref,
    output logic [15:0]      o_aux_ref,
    output logic [15:0]      o_out_freq,
    output logic             o_running,
    output logic [15:0]      o_keypad_ref,
    output logic [15:0]      o_serial_ref,
    output logic [15:0]      o_pid_fb,
    output logic [15:0]      o_pid_target,
    output logic [15:0]      o_disp_value,
    output logic [1:0]       o_disp_decimals,
    output logic [1:0]       o_disp_unit,
    output logic             o_rs485_tx,
    output logic             o_rs485_oe_n
);
////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic [7:0]  d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    function automatic logic [15:0] pow10(input logic [2:0] d);
        case (d)
            3'h0:    pow10 = 16'h0001;
            3'h1:    pow10 = 16'h000A;
            3'h2:    pow10 = 16'h0064;
            3'h3:    pow10 = 16'h03E8;
            default: pow10 = 16'h2710;
        endcase
    endfunction

    function automatic logic [15:0] scale_pct(input logic [31:0] v,
                                              input logic [31:0] m);
        logic [31:0] p;
        p = v * m / `PCT_FULL;
        return (p > 32'h0000_FFFF) ? 16'hFFFF : p[15:0];
    endfunction
////////////////////////////////////////////////////////////////////////////////
    // Settings latch: each field only moves when the new value is legal
    cfg_t cfg_r;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cfg_r <= '{`SRC_KEYPAD, `PF_FREQ, `SCALE_MAX, `GAIN_RST,
                       11'sh000, `FILT_RST, `DU_HZ};
        end else begin
            if (i_cfg.src <= `SRC_PID) cfg_r.src <= i_cfg.src;
            if (i_cfg.pfn <= `PF_PID_TGT) cfg_r.pfn <= i_cfg.pfn;
            if (i_cfg.scale >= `SCALE_MIN && i_cfg.scale <= `SCALE_MAX)
                cfg_r.scale <= i_cfg.scale;
            if (i_cfg.gain <= `GAIN_MAX) cfg_r.gain <= i_cfg.gain;
            if (i_cfg.bias >= -`BIAS_LIM && i_cfg.bias <= `BIAS_LIM)
                cfg_r.bias <= i_cfg.bias;
            if (i_cfg.filt <= `FILT_MAX) cfg_r.filt <= i_cfg.filt;
            if (i_cfg.unit != `DU_D1_BASE && i_cfg.unit != `DU_D2_BASE &&
                i_cfg.unit != `DU_D3_BASE && i_cfg.unit <= `DU_D3_MAX)
                cfg_r.unit <= i_cfg.unit;
        end
    end
////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; a level is taken once stages two and three agree
    logic [2:0] rx_s_r, pi_s_r;
    logic       rx_v_r, pi_v_r, pi_d_r;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rx_s_r <= 3'h7;
            pi_s_r <= 3'h0;
            rx_v_r <= 1'b1;
            pi_v_r <= 1'b0;
            pi_d_r <= 1'b0;
        end else begin
            rx_s_r <= {rx_s_r[1:0], i_rs485_rx};
            pi_s_r <= {pi_s_r[1:0], i_pulse_input_terminal};
            if (rx_s_r[1] == rx_s_r[2]) rx_v_r <= rx_s_r[2];
            if (pi_s_r[1] == pi_s_r[2]) pi_v_r <= pi_s_r[2];
            pi_d_r <= pi_v_r;
        end
    end
////////////////////////////////////////////////////////////////////////////////
    // Pulse measurement over a fixed gate, then filter, scale, gain and bias
    logic [23:0] gate_r;
    logic [15:0] pcnt_r;
    logic [31:0] filt_r, pct_r;
    wire         gate_end = (gate_r == 24'(GATE_CYC - 1));
    wire  [31:0] hz_w     = 32'(pcnt_r) * `GATE_PER_S;
    wire  [31:0] diff_w   = hz_w - filt_r;
    wire  [31:0] filt_nxt = (32'(cfg_r.filt) <= `FILT_PER_GATE) ? hz_w :
                 filt_r + 32'($signed(diff_w) * $signed(`FILT_PER_GATE)
                              / $signed(32'(cfg_r.filt)));
    wire  [31:0] norm_w   = filt_r * `PCT_FULL / 32'(cfg_r.scale);
    wire  [31:0] tgt_w    = norm_w * 32'(cfg_r.gain) / `GAIN_UNIT
                          + 32'($signed(cfg_r.bias)) * 32'sd10;
    wire  [31:0] pct_nxt  = tgt_w[31] ? 32'h0 : tgt_w;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            gate_r <= 24'h0;
            pcnt_r <= 16'h0;
            filt_r <= 32'h0;
            pct_r  <= 32'h0;
        end else begin
            gate_r <= gate_end ? 24'h0 : gate_r + 24'h1;
            if (gate_end) begin
                // An edge on the gate boundary opens the next count
                pcnt_r <= 16'(pi_v_r && !pi_d_r);
                filt_r <= filt_nxt;
            end else if (pi_v_r && !pi_d_r && pcnt_r != 16'hFFFF) begin
                pcnt_r <= pcnt_r + 16'h1;
            end
            pct_r <= pct_nxt;
        end
    end
    wire [15:0] pct16    = (pct_r > 32'h0000_FFFF) ? 16'hFFFF : pct_r[15:0];
    wire [15:0] pulse_hz = scale_pct(pct_r, 32'(i_max_freq));
////////////////////////////////////////////////////////////////////////////////
    // Keypad editing and terminal up/down references
    logic [15:0] key_ref_r, ud_ref_r;
    logic        edit_r;
    logic [2:0]  digit_r;
    wire  [15:0] kstep = pow10(digit_r);
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            key_ref_r <= `KEY_REF_RST;
            ud_ref_r  <= 16'h0;
            edit_r    <= 1'b0;
            digit_r   <= 3'h0;
        end else begin
            if (i_keys.enter) edit_r <= !edit_r;
            if (edit_r && i_keys.shift)
                digit_r <= (digit_r == 3'h4) ? 3'h0 : digit_r + 3'h1;
            if (edit_r && i_keys.up)
                key_ref_r <= (key_ref_r + kstep > i_max_freq) ? i_max_freq
                           : key_ref_r + kstep;
            else if (edit_r && i_keys.down)
                key_ref_r <= (key_ref_r < kstep) ? 16'h0
                           : key_ref_r - kstep;
            if (i_term_up)
                ud_ref_r <= (ud_ref_r + UD_STEP > i_max_freq) ? i_max_freq
                          : ud_ref_r + UD_STEP;
            else if (i_term_down)
                ud_ref_r <= (ud_ref_r < UD_STEP) ? 16'h0 : ud_ref_r - UD_STEP;
        end
    end
////////////////////////////////////////////////////////////////////////////////
    // Source selection
    logic [15:0] ser_ref_r;
    wire  [15:0] ai_m = 16'(32'(i_analog_input_master) * 32'(i_max_freq)
                            / 32'd4095);
    wire  [15:0] ai_a = 16'(32'(i_analog_input_auxiliary) * 32'(i_max_freq)
                            / 32'd4095);
    wire  [15:0] pls_ref = (cfg_r.pfn == `PF_FREQ) ? pulse_hz
                                                   : o_freq_ref;
    wire  [15:0] ref_w =
        (cfg_r.src == `SRC_ANALOG) ? ai_m :
        (cfg_r.src == `SRC_UPDOWN) ? ud_ref_r :
        (cfg_r.src == `SRC_SERIAL) ? ser_ref_r :
        (cfg_r.src == `SRC_PULSE)  ? pls_ref :
        (cfg_r.src == `SRC_PID)    ? i_pid_out :
        key_ref_r;
////////////////////////////////////////////////////////////////////////////////
    // Run control and output frequency ramp
    logic [23:0] ramp_r;
    logic [15:0] out_r;
    logic        run_r;
    wire  [15:0] goal = run_r ? ref_w : 16'h0;
    wire         rtick = (ramp_r == 24'(RAMP_CYC - 1));
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ramp_r <= 24'h0;
            out_r  <= 16'h0;
            run_r  <= 1'b0;
        end else begin
            ramp_r <= rtick ? 24'h0 : ramp_r + 24'h1;
            if (i_keys.stop) run_r <= 1'b0;
            else if (i_keys.run) run_r <= 1'b1;
            if (rtick && out_r < goal)
                out_r <= (goal - out_r < RAMP_STEP) ? goal
                       : out_r + RAMP_STEP;
            else if (rtick && out_r > goal)
                out_r <= (out_r - goal < RAMP_STEP) ? goal
                       : out_r - RAMP_STEP;
        end
    end
////////////////////////////////////////////////////////////////////////////////
    // Display encoding
    wire [31:0] opct = (i_max_freq == 16'h0) ? 32'h0
                     : 32'(out_r) * `PCT_FULL / 32'(i_max_freq);
    wire [15:0] u    = cfg_r.unit;
    wire        d1   = (u > `DU_D1_BASE && u < `DU_D2_BASE);
    wire        d2   = (u > `DU_D2_BASE && u < `DU_D3_BASE);
    wire        d3   = (u > `DU_D3_BASE);
    wire [15:0] ubase = d3 ? `DU_D3_BASE : d2 ? `DU_D2_BASE
                      : d1 ? `DU_D1_BASE : 16'h0;
    wire [15:0] rpm  = (u < 16'h2) ? 16'h0
                     : 16'(32'(out_r) * 32'd6 / (32'(u) * 32'd5));
    wire [15:0] dsp_v = (u == `DU_HZ)      ? out_r :
                        (u == `DU_PCT)     ? 16'(opct) :
                        (u <= `DU_RPM_MAX) ? rpm :
                        scale_pct(opct, 32'(u - ubase));
    wire [1:0]  dsp_d = (u <= `DU_PCT) ? 2'h2 : d3 ? 2'h3 : d2 ? 2'h2
                      : d1 ? 2'h1 : 2'h0;
    wire [1:0]  dsp_u = (u == `DU_HZ) ? `UNIT_HZ : (u == `DU_PCT) ? `UNIT_PCT
                      : (u <= `DU_RPM_MAX) ? `UNIT_RPM : `UNIT_USER;
////////////////////////////////////////////////////////////////////////////////
    // Modbus RTU receiver, frame check and echo reply
    rx_state_t   rx_st_r;
    logic [19:0] bcnt_r, gap_r;
    logic [3:0]  bit_r, idx_r, tidx_r;
    logic [7:0]  sh_r;
    logic [7:0]  buf_r [0:7];
    logic        fdone_r, tbusy_r;
    logic [9:0]  tsh_r;
    logic [19:0] tcnt_r;
    logic [3:0]  tbit_r;
    logic [15:0] crc_w [0:6];
    assign crc_w[0] = `CRC_INIT;
    for (genvar g = 0; g < 6; g++) begin : g_crc
        assign crc_w[g+1] = crc_step(crc_w[g], buf_r[g]);
    end
    wire [15:0] wval = {buf_r[4], buf_r[5]};
    wire accept = fdone_r && buf_r[0] == NODE_ADDR &&
                  buf_r[1] == `FUNC_WRITE_REG &&
                  {buf_r[2], buf_r[3]} == `REG_FREQ_REF &&
                  crc_w[6] == {buf_r[7], buf_r[6]} &&
                  wval <= `FREQ_REF_MAX &&
                  cfg_r.src == `SRC_SERIAL;
    wire bit_end  = (bcnt_r == 20'(BIT_CYC - 1));
    wire tbit_end = (tcnt_r == 20'(BIT_CYC - 1));
    wire byte_ok  = (rx_st_r == RX_STOP) && bit_end && rx_v_r;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rx_st_r <= RX_IDLE;
            bcnt_r  <= 20'h0;
            bit_r   <= 4'h0;
            sh_r    <= 8'h0;
            idx_r   <= 4'h0;
            gap_r   <= 20'h0;
            fdone_r <= 1'b0;
        end else begin
            fdone_r <= 1'b0;
            bcnt_r  <= (rx_st_r == RX_IDLE || bit_end) ? 20'h0
                     : bcnt_r + 20'h1;
            if (rx_st_r != RX_IDLE) gap_r <= 20'h0;
            else if (gap_r != 20'(GAP_CYC)) gap_r <= gap_r + 20'h1;
            if (gap_r == 20'(GAP_CYC)) idx_r <= 4'h0; // Silence ends a frame
            case (rx_st_r)
                RX_IDLE: begin
                    if (!rx_v_r) rx_st_r <= RX_START;
                end
                RX_START: begin
                    // Half a bit in: a glitch returns to idle
                    if (bcnt_r == 20'(BIT_CYC / 2)) begin
                        rx_st_r <= rx_v_r ? RX_IDLE : RX_DATA;
                        bcnt_r  <= 20'h0;
                        bit_r   <= 4'h0;
                    end
                end
                RX_DATA: begin
                    if (bit_end) begin
                        sh_r  <= {rx_v_r, sh_r[7:1]};
                        bit_r <= bit_r + 4'h1;
                        if (bit_r == 4'h7) rx_st_r <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (bit_end) begin
                        rx_st_r <= RX_IDLE;
                        if (rx_v_r && idx_r < `FRAME_LEN) begin
                            idx_r   <= idx_r + 4'h1;
                            fdone_r <= (idx_r == `FRAME_LEN - 4'h1);
                        end
                    end
                end
                default: rx_st_r <= RX_IDLE;
            endcase
        end
    end
    always_ff @(posedge i_clk) begin
        if (byte_ok && idx_r < `FRAME_LEN) buf_r[idx_r[2:0]] <= sh_r;
    end
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ser_ref_r <= 16'h0;
            tbusy_r   <= 1'b0;
            tidx_r    <= 4'h0;
            tsh_r     <= 10'h3FF;
            tcnt_r    <= 20'h0;
            tbit_r    <= 4'h0;
        end else begin
            if (accept) ser_ref_r <= wval;
            tcnt_r <= (!tbusy_r || tbit_end) ? 20'h0 : tcnt_r + 20'h1;
            if (accept && !tbusy_r) begin
                tbusy_r <= 1'b1;
                tidx_r  <= 4'h1;
                tsh_r   <= {1'b1, buf_r[0], 1'b0};
                tbit_r  <= 4'h0;
            end else if (tbusy_r && tbit_end) begin
                tsh_r  <= {1'b1, tsh_r[9:1]};
                tbit_r <= tbit_r + 4'h1;
                if (tbit_r == 4'h9) begin
                    tbit_r <= 4'h0;
                    tidx_r <= tidx_r + 4'h1;
                    if (tidx_r == `FRAME_LEN) tbusy_r <= 1'b0;
                    else tsh_r <= {1'b1, buf_r[tidx_r[2:0]], 1'b0};
                end
            end
        end
    end
////////////////////////////////////////////////////////////////////////////////
    // Output registers
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_freq_ref      <= 16'h0;
            o_aux_ref       <= 16'h0;
            o_out_freq      <= 16'h0;
            o_running       <= 1'b0;
            o_keypad_ref    <= `KEY_REF_RST;
            o_serial_ref    <= 16'h0;
            o_pid_fb        <= 16'h0;
            o_pid_target    <= 16'h0;
            o_disp_value    <= 16'h0;
            o_disp_decimals <= 2'h2;
            o_disp_unit     <= `UNIT_HZ;
            o_rs485_tx      <= 1'b1;
            o_rs485_oe_n    <= 1'b1;
        end else begin
            o_freq_ref      <= ref_w;
            o_aux_ref       <= ai_a;
            o_out_freq      <= out_r;
            o_running       <= run_r;
            o_keypad_ref    <= key_ref_r;
            o_serial_ref    <= ser_ref_r;
            if (cfg_r.pfn == `PF_PID_FB) o_pid_fb <= pct16;
            if (cfg_r.pfn == `PF_PID_TGT) o_pid_target <= pct16;
            o_disp_value    <= dsp_v;
            o_disp_decimals <= dsp_d;
            o_disp_unit     <= dsp_u;
            o_rs485_tx      <= tbusy_r ? tsh_r[0] : 1'b1;
            o_rs485_oe_n    <= !tbusy_r;
        end
    end
endmodule // speed_reference_selector
`default_nettype wire

// >>> hw/speed_ref_params.svh
// Constants of the speed reference selector
`ifndef SPEED_REF_PARAMS_SVH
`define SPEED_REF_PARAMS_SVH
`define CLK_HZ          100000000
`define BAUD_DEF        9600
`define NODE_ADDR_DEF   8'h01
`define SRC_KEYPAD      3'h0
`define SRC_ANALOG      3'h1
`define SRC_UPDOWN      3'h2
`define SRC_SERIAL      3'h3
`define SRC_PULSE       3'h4
`define SRC_PID         3'h5
`define PF_FREQ         2'h0
`define PF_PID_FB       2'h1
`define PF_PID_TGT      2'h2
`define REG_FREQ_REF    16'h2502
`define FUNC_WRITE_REG  8'h06
`define FRAME_LEN       4'h8
`define CRC_INIT        16'hFFFF
`define CRC_POLY        16'hA001
`define FREQ_REF_MAX    16'h9C40
`define SCALE_MIN       16'h0032
`define SCALE_MAX       16'h7D00
`define GAIN_MAX        14'h2710
`define BIAS_LIM        11'sh3E8
`define FILT_MAX        8'hC8
`define GAIN_RST        14'h03E8
`define FILT_RST        8'h0A
`define KEY_REF_RST     16'h01F4
`define PCT_FULL        32'h0000_2710
`define GAIN_UNIT       32'h0000_03E8
`define GATE_MS         100
`define GATE_PER_S      10
`define FILT_PER_GATE   32'h0000_000A
`define GAP_BIT_TIMES   35
`define RAMP_MS         1
`define DU_HZ           16'h0000
`define DU_PCT          16'h0001
`define DU_RPM_MAX      16'h0027
`define DU_INT_MAX      16'h270F
`define DU_D1_BASE      16'h2710
`define DU_D2_BASE      16'h4E20
`define DU_D3_BASE      16'h7530
`define DU_D3_MAX       16'h9C3F
`define UNIT_HZ         2'h0
`define UNIT_PCT        2'h1
`define UNIT_RPM        2'h2
`define UNIT_USER       2'h3
`endif

// >>> hw/speed_ref_pkg.sv
// Types of the speed reference selector
package speed_ref_pkg;
    typedef struct packed {
        logic [2:0]         src;
        logic [1:0]         pfn;
        logic [15:0]        scale;
        logic [13:0]        gain;
        logic signed [10:0] bias;
        logic [7:0]         filt;
        logic [15:0]        unit;
    } cfg_t;
    typedef struct packed {
        logic run;
        logic stop;
        logic enter;
        logic shift;
        logic up;
        logic down;
    } keys_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
endpackage

// >>> verification/speed_ref_checker.sv
// Port assertions for the speed reference selector
`timescale 1ns/1ps
`default_nettype none
module speed_ref_checker
    import speed_ref_pkg::*;
#(
    parameter logic [15:0] RAMP_STEP = 16'h0001
) (
    input wire logic        i_clk,
    input wire logic        i_resetn,
    input wire cfg_t        i_cfg,
    input wire keys_t       i_keys,
    input wire logic [15:0] o_freq_ref,
    input wire logic [15:0] o_out_freq,
    input wire logic        o_running,
    input wire logic [15:0] o_keypad_ref,
    input wire logic [15:0] o_serial_ref,
    input wire logic [1:0]  o_disp_decimals,
    input wire logic [1:0]  o_disp_unit,
    input wire logic        o_rs485_tx,
    input wire logic        o_rs485_oe_n
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
////////////////////////////////////////////////////////////////////////////
    // Run state and its output register make two stages after the key
    a_run_starts: assert property (i_keys.run && !i_keys.stop |->
        ##2 o_running) else $error("run key did not start the drive");
    a_stop_wins: assert property (i_keys.stop |-> ##2 !o_running)
        else $error("stop key did not stop the drive");
    a_stopped_zero: assert property (!o_running && !i_keys.run &&
        o_out_freq == 16'h0000 |=> o_out_freq == 16'h0000)
        else $error("output moved while stopped at zero");
    a_ramp_step: assert property ($changed(o_out_freq) |->
        (o_out_freq - $past(o_out_freq) == RAMP_STEP) ||
        ($past(o_out_freq) - o_out_freq == RAMP_STEP))
        else $error("output frequency jumped");
    // Five cycles cover the latch and the accept pipeline
    a_serial_lock: assert property ((i_cfg.src != 3'h3) [*5] |->
        $stable(o_serial_ref)) else $error("serial write taken off source");
    a_serial_sel: assert property ((i_cfg.src == 3'h3 &&
        $stable(o_serial_ref)) [*4] |-> o_freq_ref == o_serial_ref)
        else $error("serial reference not selected");
    a_keypad_sel: assert property ((i_cfg.src == 3'h0 &&
        $stable(o_keypad_ref)) [*4] |-> o_freq_ref == o_keypad_ref)
        else $error("keypad reference not selected");
    a_echo_start: assert property ($fell(o_rs485_oe_n) |-> !o_rs485_tx)
        else $error("reply does not open with a start bit");
    a_idle_high: assert property (o_rs485_oe_n |-> o_rs485_tx)
        else $error("serial output not idle high");
    a_hz_unit: assert property ((i_cfg.unit == 16'h0000) [*4] |->
        o_disp_unit == 2'h0 && o_disp_decimals == 2'h2)
        else $error("hertz display wrong");
    c_run: cover property ($rose(o_running));
    c_reply: cover property ($fell(o_rs485_oe_n));
    c_serial: cover property ($changed(o_serial_ref));
endmodule // speed_ref_checker
`default_nettype wire

// >>> verification/modbus_master.sv
// Modbus RTU master model driving the device receive line
`timescale 1ns/1ps
`default_nettype none
module modbus_master #(
    parameter int BIT_CYC = 16
) (
    input  wire logic i_clk,
    output var logic  o_line
);
    initial o_line = 1'b1;
    // Frame bytes leave high byte first; start, 8 data LSB first, stop
    task automatic send_frame(input logic [63:0] f);
        logic [9:0] sh;
        for (int b = 7; b >= 0; b--) begin
            sh = {1'b1, f[b*8 +: 8], 1'b0};
            for (int i = 0; i < 10; i++) begin
                o_line = sh[i];
                repeat (BIT_CYC) @(posedge i_clk);
                #1;
            end
        end
        // Silence past the echo so frames never overlap the reply
        repeat (BIT_CYC * 100) @(posedge i_clk);
        #1;
    endtask
endmodule // modbus_master
`default_nettype wire

// >>> verification/tb_top.sv
// Self-checking testbench for the speed reference selector
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import speed_ref_pkg::*;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    cfg_t        cfg;
    keys_t       keys;
    logic        rx, running, oe_n, tup = 1'b0, tdn = 1'b0, pls = 1'b0;
    logic [15:0] pid, mx, freq_ref, out_freq, key_ref, ser_ref, aux_ref;
    logic [15:0] disp, pid_fb;
    logic [1:0]  dec, unit;
    int          bad_count = 0;
    int          checked = 0;
    int          replies = 0;
    logic [2:0]  srcs [4] = '{3'h1, 3'h5, 3'h0, 3'h6};
    logic [15:0] refs [4] = '{16'h0FFF, 16'h0123, 16'h01F4, 16'h01F4};
    logic [15:0] codes [7] = '{16'h0001, 16'h0028, 16'h2711, 16'h2710,
                               16'h7531, 16'h0004, 16'h0000};
    logic [3:0]  dsp [7] = '{4'h6, 4'hC, 4'hD, 4'hD, 4'hF, 4'h8, 4'h2};
    always #5 clk = ~clk;
    always @(negedge oe_n) replies++;
    // Pulse train of 20-cycle period only while the pulse source is chosen
    always begin
        step(10);
        pls = (cfg.src == 3'h4) & ~pls;
    end
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin bad_count++; \
    $display("wrong value at %0t: %h vs %h", $time, a, e); end end
////////////////////////////////////////////////////////////////////////////
    speed_reference_selector #(.BIT_CYC(16), .GAP_CYC(600),
        .GATE_CYC(1000), .RAMP_CYC(10)) DUT (.i_clk(clk), .i_resetn(resetn),
        .i_cfg(cfg), .i_keys(keys), .i_term_up(tup), .i_term_down(tdn),
        .i_analog_input_master(12'hFFF), .i_analog_input_auxiliary(12'h800),
        .i_pid_out(pid), .i_max_freq(mx), .i_pulse_input_terminal(pls),
        .i_rs485_rx(rx), .o_freq_ref(freq_ref), .o_aux_ref(aux_ref),
        .o_out_freq(out_freq), .o_running(running), .o_keypad_ref(key_ref),
        .o_serial_ref(ser_ref), .o_pid_fb(pid_fb), .o_pid_target(),
        .o_disp_value(disp), .o_disp_decimals(dec), .o_disp_unit(unit),
        .o_rs485_tx(), .o_rs485_oe_n(oe_n));
    modbus_master #(.BIT_CYC(16)) MASTER (.i_clk(clk), .o_line(rx));
////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checked %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic press(input keys_t k);
        keys = k;
        step(1);
        keys = '0;
        step(1);
    endtask
    // Ramp takes ten cycles a step, so 8000 covers a full 5.00 Hz swing
    task automatic wait_out(input logic [15:0] v);
        int n;
        n = 0;
        while (out_freq !== v && n < 8000) begin
            step(1);
            n++;
        end
        if (n == 8000) begin
            bad_count++;
            finish_test();
        end
    endtask
    task automatic send_chk(input logic [63:0] f, input logic [15:0] v);
        MASTER.send_frame(f);
        step(8);
        `CHK(ser_ref, v);
    endtask
    initial begin
        #1000000;
        bad_count++;
        finish_test();
    end
    initial begin
        cfg = '{3'h0, 2'h0, 16'h7D00, 14'h03E8, 11'sh000, 8'h0A, 16'h0000};
        keys = '0;
        pid = 16'h0123;
        mx = 16'h0FFF;
        step(6);
        resetn = 1'b1;
        step(4);
        `CHK(key_ref, 16'h01F4);
        `CHK(freq_ref, 16'h01F4);
        $display("test reset done");
        press(6'b100000);
        wait_out(16'h01F4);
        `CHK(running, 1'b1);
        `CHK(disp, 16'h01F4);
        press(6'b010000);
        wait_out(16'h0000);
        `CHK(running, 1'b0);
        $display("test keypad run done");
        press(6'b001000);
        press(6'b000100);
        press(6'b000010);
        `CHK(key_ref, 16'h01FE);
        press(6'b000001);
        press(6'b001000);
        `CHK(key_ref, 16'h01F4);
        $display("test keypad edit done");
        foreach (srcs[i]) begin
            cfg.src = srcs[i];
            step(4);
            `CHK(freq_ref, refs[i]);
        end
        `CHK(aux_ref, 16'h0800);
        $display("test source select done");
        cfg.src = 3'h2;
        tup = 1'b1;
        step(3);
        tup = 1'b0;
        tdn = 1'b1;
        step(1);
        tdn = 1'b0;
        step(4);
        `CHK(freq_ref, 16'h0002);
        $display("test up down done");
        cfg.src = 3'h4;
        cfg.scale = 16'h03E8;
        step(2600);
        `CHK(freq_ref, 16'h07FF);
        cfg.pfn = 2'h1;
        step(4);
        `CHK(pid_fb, 16'h1388);
        `CHK(freq_ref, 16'h07FF);
        $display("test pulse input done");
        foreach (codes[i]) begin
            cfg.unit = codes[i];
            step(4);
            `CHK({unit, dec}, dsp[i]);
        end
        $display("test display unit done");
        send_chk(64'h0106250203E823B8, 16'h0000);
        cfg.src = 3'h3;
        send_chk(64'h0106250203E823B8, 16'h03E8);
        send_chk(64'h010625020BB82445, 16'h03E8);
        send_chk(64'h0206250217702D12, 16'h03E8);
        send_chk(64'h0106250217702D12, 16'h1770);
        `CHK(freq_ref, 16'h1770);
        `CHK(replies, 2);
        $display("test serial reference done");
        finish_test();
    end
endmodule // tb_top
bind speed_reference_selector speed_ref_checker #(.RAMP_STEP(RAMP_STEP)) chk (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_cfg(i_cfg), .i_keys(i_keys),
    .o_freq_ref(o_freq_ref), .o_out_freq(o_out_freq), .o_running(o_running),
    .o_keypad_ref(o_keypad_ref), .o_serial_ref(o_serial_ref),
    .o_disp_decimals(o_disp_decimals), .o_disp_unit(o_disp_unit),
    .o_rs485_tx(o_rs485_tx), .o_rs485_oe_n(o_rs485_oe_n));
`default_nettype wire
